// >>> design/fphd_cfg.svh
`ifndef FPHD_CFG_SVH
`define FPHD_CFG_SVH

// header dword field positions
`define FPHD_LEN_HI 31
`define FPHD_LEN_LO 24
`define FPHD_MAJ_HI 23
`define FPHD_MAJ_LO 16
`define FPHD_MIN_HI 15
`define FPHD_MIN_LO 8
`define FPHD_LSB_HI 7
`define FPHD_LSB_LO 0
`define FPHD_MSB_HI 31
`define FPHD_MSB_LO 24
`define FPHD_PTR_HI 23
`define FPHD_PTR_LO 0
`define FPHD_ALIGN_HI 1
`define FPHD_ALIGN_LO 0

// identifier ranges
`define FPHD_MSB_RSVD 8'h00
`define FPHD_MSB_VEND_LO 8'h01
`define FPHD_MSB_VEND_HI 8'h7f
`define FPHD_MSB_STD_LO 8'h80
`define FPHD_MSB_BASIC 8'hff
`define FPHD_LSB_BASIC 8'h00

// assigned identifiers
`define FPHD_ID_BASIC 16'hff00
`define FPHD_ID_SECTOR_MAP 16'hff81
`define FPHD_ID_FOUR_BYTE 16'hff84
`define FPHD_ID_MONO_CTR 16'hff03
`define FPHD_ID_OCTAL_DDR 16'hff0a
`define FPHD_ID_QUAD_DDR 16'hff8d
`define FPHD_ID_XSPI_P1 16'hff05
`define FPHD_ID_XSPI_P2 16'hff06

// header walk and address arithmetic
`define FPHD_FIRST_HDR 24'h000008
`define FPHD_HDR_BYTES 24'h000008
`define FPHD_BYTE_SHIFT 2
`define FPHD_WORD_SHIFT 1
`define FPHD_ONE8 8'h01
`define FPHD_ZERO8 8'h00
`define FPHD_ZERO2 2'h0

`endif

// >>> design/fphd_pkg.sv
package fphd_pkg;

  typedef enum logic [2:0] {
    CL_NONE = 3'b000,
    CL_BASIC = 3'b001,
    CL_VEND_SPEC = 3'b010,
    CL_VEND_FUNC = 3'b011,
    CL_STD_FUNC = 3'b100,
    CL_ILLEGAL = 3'b101
  } fphd_class_e;

  typedef enum logic [3:0] {
    TB_UNKNOWN = 4'b0000,
    TB_BASIC = 4'b0001,
    TB_SECTOR_MAP = 4'b0010,
    TB_FOUR_BYTE = 4'b0011,
    TB_MONOTONIC_COUNTER_TABLE = 4'b0100,
    TB_OCTAL_DDR = 4'b0101,
    TB_QUAD_DDR = 4'b0110,
    TB_XSPI_P1 = 4'b0111,
    TB_XSPI_P2 = 4'b1000
  } fphd_table_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_WALK = 1'b1
  } fphd_state_e;

  typedef struct packed {
    logic [7:0] table_length;
    logic [7:0] major_rev;
    logic [7:0] minor_rev;
    logic [15:0] param_id;
    logic [23:0] table_start_pointer;
    fphd_class_e cls;
    fphd_table_e table_kind;
    logic [7:0] vendor_bank;
    logic [7:0] vendor_code;
    logic [23:0] dword_addr;
    logic err_illegal;
    logic err_reserved;
    logic err_align;
    logic err_lsb_basic;
    logic error;
  } fphd_result_s;

endpackage

// >>> design/fphd_decoder.sv
`timescale 1ns/100ps
`include "fphd_cfg.svh"
// How it works
// RL1 - second header dword bits 31:24 carry the identifier high byte
// RL2 - second dword low 24 bits are the table pointer, dword aligned
// RL3 - high byte 01h-7Fh with odd low byte: vendor-specific table
// RL4 - high byte 01h-7Fh with even low byte: vendor function table
// RL5 - high byte 80h-FFh with even low byte: standard function table
// RL6 - high byte 80h-FFh with odd low byte is illegal and flagged
// RL7 - low byte 00h must pair with high byte FFh only
// RL8 - low byte 00h alone identifies the basic table
// RL9 - high byte 00h is reserved, never used
// RL10 - vendor high byte 01h-7Fh gives the maker's bank number
// RL11 - maker code is seven data bits plus odd parity on top
// RL12 - recognise FF00 basic, FF81 sector map, FF84 four-byte table
// RL13 - recognise FF03 counters, FF0A octal and FF8D quad mode tables
// RL14 - recognise FF05, FF06 profile tables; FF0F stays unknown
// RL15 - byte address of dword n is pointer plus (n-1) times four
// RL16 - in profile 2.0 address is pointer plus (n-1) times two
// RL17 - older basic header revisions are not required
// RL18 - optional headers may be absent and are tolerated
// RL19 - vendor-specific tables report the owning vendor code
// RL20 - first dword holds length, major, minor, identifier low byte
// RL21 - headers are two dwords, contiguous from 08h, count from field
// RL22 - flag illegal id, reserved high byte zero, unaligned pointer (alignment is not checked in profile 2.0 mode)
module fphd_decoder (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic walk_start,
  input wire logic [7:0] header_count_field,
  input wire logic hdr_valid,
  input wire logic [31:0] hdr_dword1,
  input wire logic [31:0] hdr_dword2,
  input wire logic profile2_mode,
  input wire logic [7:0] dword_index,
  output fphd_pkg::fphd_result_s result,
  output logic result_valid,
  output logic [23:0] hdr_offset,
  output logic walk_busy,
  output logic walk_done,
  output logic basic_seen
);

  fphd_pkg::fphd_state_e state;
  fphd_pkg::fphd_state_e next_state;
  fphd_pkg::fphd_result_s next_result;
  logic [7:0] hdr_index;
  logic [7:0] id_msb;
  logic [7:0] id_lsb;
  logic [15:0] id_full;
  logic [23:0] ptr;
  logic [7:0] n_m1;
  logic lsb_odd;
  logic last_hdr;

  assign id_msb = hdr_dword2[`FPHD_MSB_HI:`FPHD_MSB_LO]; // RL1
  assign id_lsb = hdr_dword1[`FPHD_LSB_HI:`FPHD_LSB_LO]; // RL20
  assign id_full = {id_msb, id_lsb};
  assign ptr = hdr_dword2[`FPHD_PTR_HI:`FPHD_PTR_LO]; // RL2
  assign n_m1 = dword_index - `FPHD_ONE8;
  assign lsb_odd = ^id_lsb; // RL11
  // header_count_field holds count minus one
  assign last_hdr = (hdr_index == header_count_field); // RL21

  always_comb begin
    next_result = '0;
    next_result.table_length = hdr_dword1[`FPHD_LEN_HI:`FPHD_LEN_LO]; // RL20
    next_result.major_rev = hdr_dword1[`FPHD_MAJ_HI:`FPHD_MAJ_LO]; // RL20
    next_result.minor_rev = hdr_dword1[`FPHD_MIN_HI:`FPHD_MIN_LO]; // RL20
    next_result.param_id = id_full;
    next_result.table_start_pointer = ptr;
    // low byte 00h wins first so legacy-style ids still read basic
    if (id_lsb == `FPHD_LSB_BASIC) begin
      next_result.cls = fphd_pkg::CL_BASIC; // RL8
    end else if (id_msb == `FPHD_MSB_RSVD) begin
      next_result.cls = fphd_pkg::CL_NONE; // RL9
    end else if (id_msb <= `FPHD_MSB_VEND_HI) begin
      if (lsb_odd) begin
        next_result.cls = fphd_pkg::CL_VEND_SPEC; // RL3
        next_result.vendor_code = id_lsb; // RL19
      end else begin
        next_result.cls = fphd_pkg::CL_VEND_FUNC; // RL4
      end
      next_result.vendor_bank = id_msb; // RL10
    end else if (lsb_odd) begin
      next_result.cls = fphd_pkg::CL_ILLEGAL; // RL6
    end else begin
      next_result.cls = fphd_pkg::CL_STD_FUNC; // RL5
    end
    if (id_lsb == `FPHD_LSB_BASIC) begin
      next_result.table_kind = fphd_pkg::TB_BASIC; // RL8
    end else begin
      case (id_full)
        `FPHD_ID_SECTOR_MAP: next_result.table_kind =
          fphd_pkg::TB_SECTOR_MAP; // RL12
        `FPHD_ID_FOUR_BYTE: next_result.table_kind =
          fphd_pkg::TB_FOUR_BYTE; // RL12
        `FPHD_ID_MONO_CTR: next_result.table_kind =
          fphd_pkg::TB_MONOTONIC_COUNTER_TABLE; // RL13
        `FPHD_ID_OCTAL_DDR: next_result.table_kind =
          fphd_pkg::TB_OCTAL_DDR; // RL13
        `FPHD_ID_QUAD_DDR: next_result.table_kind =
          fphd_pkg::TB_QUAD_DDR; // RL13
        `FPHD_ID_XSPI_P1: next_result.table_kind =
          fphd_pkg::TB_XSPI_P1; // RL14
        `FPHD_ID_XSPI_P2: next_result.table_kind =
          fphd_pkg::TB_XSPI_P2; // RL14
        default: next_result.table_kind = fphd_pkg::TB_UNKNOWN; // RL14
      endcase
    end
    // word pointer in profile 2.0 halves the dword stride
    if (profile2_mode) begin
      next_result.dword_addr = ptr +
        (24'(n_m1) << `FPHD_WORD_SHIFT); // RL16
    end else begin
      next_result.dword_addr = ptr +
        (24'(n_m1) << `FPHD_BYTE_SHIFT); // RL15
    end
    next_result.err_illegal = (id_msb >= `FPHD_MSB_STD_LO) && lsb_odd; // RL6
    next_result.err_reserved = (id_msb == `FPHD_MSB_RSVD); // RL9
    // alignment only checked on byte pointers
    next_result.err_align = !profile2_mode &&
      (ptr[`FPHD_ALIGN_HI:`FPHD_ALIGN_LO] != `FPHD_ZERO2); // RL2
    next_result.err_lsb_basic = (id_lsb == `FPHD_LSB_BASIC) &&
      (id_msb != `FPHD_MSB_BASIC); // RL7
    next_result.error = next_result.err_illegal | next_result.err_reserved |
      next_result.err_align | next_result.err_lsb_basic; // RL22
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= hdr_valid;
      if (hdr_valid) begin
        result <= next_result;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      fphd_pkg::ST_IDLE: begin
        if (walk_start) begin
          next_state = fphd_pkg::ST_WALK;
        end
      end
      fphd_pkg::ST_WALK: begin
        if (walk_start) begin
          next_state = fphd_pkg::ST_WALK;
        end else if (hdr_valid && last_hdr) begin
          next_state = fphd_pkg::ST_IDLE; // RL21
        end
      end
      default: next_state = fphd_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= fphd_pkg::ST_IDLE;
      walk_busy <= 1'b0;
      walk_done <= 1'b0;
    end else begin
      state <= next_state;
      walk_busy <= (next_state == fphd_pkg::ST_WALK);
      walk_done <= (state == fphd_pkg::ST_WALK) && !walk_start &&
        hdr_valid && last_hdr;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hdr_index <= `FPHD_ZERO8;
      hdr_offset <= `FPHD_FIRST_HDR;
    end else if (walk_start) begin
      hdr_index <= `FPHD_ZERO8;
      hdr_offset <= `FPHD_FIRST_HDR; // RL21
    end else if (state == fphd_pkg::ST_WALK && hdr_valid) begin
      hdr_index <= hdr_index + `FPHD_ONE8;
      hdr_offset <= hdr_offset + `FPHD_HDR_BYTES; // RL21
    end
  end

  // no demand for older revisions or optional headers: only notes basic
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      basic_seen <= 1'b0;
    end else if (hdr_valid && id_lsb == `FPHD_LSB_BASIC) begin
      basic_seen <= 1'b1; // RL17
    end else if (walk_start) begin
      basic_seen <= 1'b0; // RL18
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [23:0] chk_exp_byte;
  logic [23:0] chk_exp_word;
  assign chk_exp_byte = ptr + 24'(n_m1) * 24'h000004;
  assign chk_exp_word = ptr + 24'(n_m1) * 24'h000002;

  sequence s_hdr_in;
    hdr_valid;
  endsequence
  sequence s_out_ready;
    ##1 result_valid;
  endsequence

  chk_hdr_fields: assert property ( // RL20
    s_hdr_in |-> s_out_ready ##0
    result.table_length == $past(hdr_dword1[31:24]) &&
    result.param_id[7:0] == $past(hdr_dword1[7:0]))
    else $error("header first dword fields wrong");
  chk_id_msb: assert property ( // RL1
    hdr_valid |=> result.param_id[15:8] == $past(hdr_dword2[31:24]))
    else $error("identifier high byte wrong");
  chk_pointer: assert property ( // RL2
    hdr_valid |=> result.table_start_pointer == $past(hdr_dword2[23:0]))
    else $error("table pointer wrong");
  chk_illegal_id: assert property ( // RL6
    hdr_valid && id_msb >= 8'h80 && lsb_odd |=>
    result.cls == fphd_pkg::CL_ILLEGAL && result.error)
    else $error("illegal identifier not flagged");
  chk_vendor_spec: assert property ( // RL3
    hdr_valid && id_msb >= 8'h01 && id_msb <= 8'h7f && lsb_odd |=>
    result.cls == fphd_pkg::CL_VEND_SPEC && result.vendor_bank != 8'h00)
    else $error("vendor table not classified");
  chk_basic_legacy: assert property ( // RL8
    hdr_valid && id_lsb == 8'h00 |=> result.table_kind == fphd_pkg::TB_BASIC)
    else $error("basic table not recognised");
  chk_byte_addr: assert property ( // RL15
    hdr_valid && !profile2_mode |=> result.dword_addr == $past(chk_exp_byte))
    else $error("byte address wrong");
  chk_word_addr: assert property ( // RL16
    hdr_valid && profile2_mode |=> result.dword_addr == $past(chk_exp_word))
    else $error("word address wrong");
  chk_align_err: assert property ( // RL22
    hdr_valid && !profile2_mode && hdr_dword2[1:0] != 2'h0 |=> result.error)
    else $error("unaligned pointer not flagged");
  chk_walk_start: assert property ( // RL21
    walk_start |=> walk_busy && hdr_offset == 24'h000008 ##1
    (!$past(hdr_valid) || $past(walk_start) || hdr_offset == 24'h000010))
    else $error("header walk start wrong");

endmodule // fphd_decoder

// >>> test/fphd_flash_model.sv
`timescale 1ns/100ps
module fphd_flash_model (
  input wire logic [23:0] rd_offset,
  output logic [31:0] dword1,
  output logic [31:0] dword2
);
  logic [31:0] mem [0:31];

  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = ~i;
    end
  end

  // headers sit two dwords apart from 08h onwards
  always_comb begin
    if (rd_offset < 24'h000080 && rd_offset[2:0] == 3'h0) begin
      dword1 = mem[rd_offset[6:2]];
      dword2 = mem[rd_offset[6:2] + 5'h01];
    end else begin
      // nothing stored here: a changing pattern, never the last value
      dword1 = ~{8'h00, rd_offset};
      dword2 = {rd_offset, 8'h5a};
    end
  end

  // only legal ids are loaded: no odd-parity high-range ids, no 00h msb
  // and a 00h lsb only with ffh; one current basic header suffices and
  // absent optional functions simply get no header
  task automatic load_hdr(input int n, input logic [15:0] id,
      input logic [7:0] len, input logic [23:0] ptr);
    mem[2 + 2 * n] = {len, 8'h01, 8'h00, id[7:0]};
    mem[3 + 2 * n] = {id[15:8], ptr};
  endtask
endmodule // fphd_flash_model

// >>> test/flash_param_header_decoder_bench.sv
`timescale 1ns/100ps
module flash_param_header_decoder_bench;
  localparam int RW = $bits(fphd_pkg::fphd_result_s);
  logic clk, rst_b, walk_start, hdr_valid, p2, hv_q;
  logic result_valid, walk_busy, walk_done, basic_seen;
  logic [7:0] hcf, idx;
  logic [31:0] d1, d2, m1, m2, a, b;
  logic [23:0] hdr_offset;
  fphd_pkg::fphd_result_s result, e;
  fphd_pkg::fphd_result_s expq[$];
  logic [15:0] ids [14] = '{16'hff00, 16'hff81, 16'hff84, 16'hff03,
    16'hff0a, 16'hff8d, 16'hff05, 16'hff06, 16'hff0f, 16'h0143,
    16'h7f03, 16'h8001, 16'h0003, 16'h1200};
  int fails, cmp_count, seed;

  fphd_decoder u_dut (.clk(clk), .rst_b(rst_b), .walk_start(walk_start),
    .header_count_field(hcf), .hdr_valid(hdr_valid), .hdr_dword1(d1),
    .hdr_dword2(d2), .profile2_mode(p2), .dword_index(idx),
    .result(result), .result_valid(result_valid), .hdr_offset(hdr_offset),
    .walk_busy(walk_busy), .walk_done(walk_done), .basic_seen(basic_seen));
  fphd_flash_model u_flash (.rd_offset(hdr_offset), .dword1(m1),
    .dword2(m2));

  function automatic fphd_pkg::fphd_result_s ref_dec(input logic [31:0] x,
      input logic [31:0] y, input logic w, input logic [7:0] n);
    fphd_pkg::fphd_result_s r;
    logic [7:0] m, l, k;
    m = y[31:24];
    l = x[7:0];
    k = n - 8'h01;
    r = '0;
    {r.table_length, r.major_rev, r.minor_rev} = x[31:8];
    r.param_id = {m, l};
    r.table_start_pointer = y[23:0];
    if (l == 8'h00) r.cls = fphd_pkg::CL_BASIC;
    else if (m == 8'h00) r.cls = fphd_pkg::CL_NONE;
    else if (m < 8'h80)
      r.cls = ^l ? fphd_pkg::CL_VEND_SPEC : fphd_pkg::CL_VEND_FUNC;
    else r.cls = ^l ? fphd_pkg::CL_ILLEGAL : fphd_pkg::CL_STD_FUNC;
    case ({m, l})
      16'hff81: r.table_kind = fphd_pkg::TB_SECTOR_MAP;
      16'hff84: r.table_kind = fphd_pkg::TB_FOUR_BYTE;
      16'hff03: r.table_kind = fphd_pkg::TB_MONOTONIC_COUNTER_TABLE;
      16'hff0a: r.table_kind = fphd_pkg::TB_OCTAL_DDR;
      16'hff8d: r.table_kind = fphd_pkg::TB_QUAD_DDR;
      16'hff05: r.table_kind = fphd_pkg::TB_XSPI_P1;
      16'hff06: r.table_kind = fphd_pkg::TB_XSPI_P2;
      default: r.table_kind = fphd_pkg::TB_UNKNOWN;
    endcase
    if (l == 8'h00) r.table_kind = fphd_pkg::TB_BASIC;
    if (r.cls == fphd_pkg::CL_VEND_SPEC || r.cls == fphd_pkg::CL_VEND_FUNC)
      r.vendor_bank = m;
    if (r.cls == fphd_pkg::CL_VEND_SPEC) r.vendor_code = l;
    r.dword_addr = y[23:0] + (w ? {15'h0, k, 1'b0} : {14'h0, k, 2'b00});
    r.err_illegal = (r.cls == fphd_pkg::CL_ILLEGAL);
    r.err_reserved = (m == 8'h00);
    r.err_align = !w && y[1:0] != 2'h0;
    r.err_lsb_basic = (l == 8'h00) && (m != 8'hff);
    r.error = r.err_illegal | r.err_reserved | r.err_align | r.err_lsb_basic;
    return r;
  endfunction

  task automatic chk(input logic [RW-1:0] seen, input logic [RW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic send(input logic [31:0] x, input logic [31:0] y);
    d1 = x;
    d2 = y;
    hdr_valid = 1'b1;
    expq.push_back(ref_dec(x, y, p2, idx));
    tick();
  endtask

  task automatic conclude();
    $display("counts: compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    #200000;
    fails++;
    conclude();
  end

  always @(posedge clk) hv_q <= hdr_valid;

  always @(negedge clk) begin
    if (rst_b) begin
      chk(result_valid, hv_q);
      if (result_valid === 1'b1) begin
        if (expq.size() == 0) begin
          chk(1'b1, 1'b0);
        end else begin
          e = expq.pop_front();
          chk(result, e);
        end
      end
    end
  end

  initial begin
    seed = 32'h6b258dff;
    {fails, cmp_count} = '0;
    {rst_b, walk_start, hdr_valid, p2, hv_q} = '0;
    {hcf, d1, d2} = '0;
    idx = 8'h01;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    chk({hdr_offset, walk_busy, basic_seen, result}, {24'h8, 2'b0, RW'(0)});
    $display("test reset done");
    u_flash.load_hdr(0, 16'hff00, 8'h09, 24'h000100);
    u_flash.load_hdr(1, 16'hff00, 8'h10, 24'h000200);
    u_flash.load_hdr(2, 16'hff84, 8'h02, 24'h000080);
    u_flash.load_hdr(3, 16'h0143, 8'h07, 24'h000300);
    hcf = 8'h03;
    walk_start = 1'b1;
    tick();
    walk_start = 1'b0;
    for (int i = 0; i < 4; i++) begin
      chk({walk_busy, walk_done, hdr_offset}, {2'b10, 24'h8 + 24'(8 * i)});
      send(m1, m2);
    end
    hdr_valid = 1'b0;
    chk({walk_busy, walk_done, hdr_offset, basic_seen}, {2'b01, 24'h28, 1'b1});
    tick();
    chk(walk_done, 1'b0);
    send(32'h01000084, 32'hff000080);
    hdr_valid = 1'b0;
    tick();
    chk(hdr_offset, 24'h28);
    walk_start = 1'b1;
    tick();
    walk_start = 1'b0;
    chk(basic_seen, 1'b0);
    $display("test walk done");
    for (int i = 0; i < 14; i++) begin
      p2 = i[0];
      idx = 8'(i + 1);
      send({24'h100100, ids[i][7:0]}, {ids[i][15:8], 24'h000100 + 24'(i)});
    end
    $display("test id table done");
    repeat (200) begin
      a = $random(seed);
      b = $random(seed);
      if (b[31:24] == 8'h00) b[31] = 1'b1;
      p2 = a[8] ^ b[9];
      idx = (b[7:0] == 8'h00) ? 8'h01 : b[7:0];
      send(a, b);
    end
    hdr_valid = 1'b0;
    tick();
    tick();
    chk(expq.size(), 0);
    $display("test random done");
    conclude();
  end
endmodule // flash_param_header_decoder_bench
